/* File: hdl/lsa_limit_alert.sv */
`timescale 1ns/1ps

// Function
// - Start bit write begins monitoring cycle
// - Start bit is set after reset
// - Channels converted in turn, repeat until stopped
// - Averaged pass takes 146 ms
// - Unaveraged pass takes 19 ms
// - Fan inputs unsynchronised with analog cycle
// - Out-of-limit result sets status bit
// - Primary bit 7 summarises secondary status
// - Sticky bits clear on read after condition
// - Overtemperature bit follows condition directly
// - Primary status bit positions per channel
// - Secondary status bit positions per source
// - Bit 5 reports thermal event when selected
// - Masks block alert only, not status
// - Alert holds while out of limit, until read
// - Summary mask gates all-masked secondary events
// - Primary mask bit positions per channel
// - Secondary mask bit positions per source
// - Alert disabled at reset, enable bit
// - Hold latch sets above limit, boosts fans
// - Hold releases below limit and bit cleared
// - Default limits 136 and 100 degrees
// - High strictly greater, low less-or-equal
// - Window comparison on every analog channel
module lsa_limit_alert
    import lsa_pkg::*;
#(
    parameter int PASS_AVG_CYCLES  = PASS_AVG_US * CLK_MHZ,
    parameter int PASS_FAST_CYCLES = PASS_FAST_US * CLK_MHZ,
    parameter logic [7:0] REMOTE_TWO_OT_LIMIT = 8'h88,
    parameter logic [7:0] REMOTE_ONE_OT_LIMIT = 8'h64
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire lsa_reg_req_t            regReq,
    output logic [7:0]                   regRdData,
    input  wire lsa_chan_t [NUM_CHANNELS-1:0] chanIn,
    input  wire logic                    convDone,
    input  wire logic [2:0]              fanSlow,
    input  wire logic                    fanFourSlow,
    input  wire logic                    thermalEventOver,
    input  wire logic                    thermalEventSel,
    input  wire logic [1:0]              diodeFault,
    input  wire logic                    overtempCond,
    input  wire logic                    holdSelTwo,
    input  wire logic [7:0]              remoteOneTemp,
    input  wire logic [7:0]              remoteTwoTemp,
    input  wire logic                    quarterAbove,
    output logic                         alertOut,
    output logic                         alertOe,
    output logic                         fansFull,
    output logic                         overtempHold,
    output logic [2:0]                   convChannel,
    output logic                         passDone
);

    // Elaboration checks: the channel map and the slot split are fixed.
    initial begin
        if (NUM_CHANNELS != 5) begin
            $error("The channel map serves exactly five channels.");
        end
        if (PASS_FAST_CYCLES < NUM_CHANNELS) begin
            $error("Unaveraged pass is shorter than one cycle a slot.");
        end
        if (PASS_AVG_CYCLES < NUM_CHANNELS) begin
            $error("Averaged pass is shorter than one cycle a slot.");
        end
        if (PASS_AVG_CYCLES < PASS_FAST_CYCLES) begin
            $error("Averaged pass must not be shorter than unaveraged.");
        end
        if (REMOTE_ONE_OT_LIMIT == 8'h00 || REMOTE_TWO_OT_LIMIT == 8'h00) begin
            $error("A hold limit of zero could never be released.");
        end
    end

    // Channel index to its primary status bit position.
    function automatic logic [7:0] chanBit(input logic [2:0] ch);
        case (ch)
            3'h0:    chanBit = 8'h02;
            3'h1:    chanBit = 8'h04;
            3'h2:    chanBit = 8'h20;
            3'h3:    chanBit = 8'h10;
            3'h4:    chanBit = 8'h40;
            default: chanBit = 8'h00;
        endcase
    endfunction : chanBit

    logic [7:0]  configOne_r;
    logic [7:0]  configTwo_r;
    logic [7:0]  configThree_r;
    logic [7:0]  configFour_r;
    logic [7:0]  primMask_r;
    logic [7:0]  secMask_r;
    logic [7:0]  primStat_r;
    logic [7:0]  secStat_r;
    lsa_state_t  state_r;
    logic [2:0]  chan_r;
    logic [31:0] slotCnt_r;
    logic [7:0]  primCond_r;
    logic        holdSet;

    wire logic monitorOn = configOne_r[START_BIT];
    wire logic avgOff    = configTwo_r[AVG_OFF_BIT];
    wire logic [31:0] slotLen = avgOff
        ? 32'(PASS_FAST_CYCLES / NUM_CHANNELS)
        : 32'(PASS_AVG_CYCLES / NUM_CHANNELS);

    wire logic rdPrim = regReq.rdEn && regReq.addr == REG_PRIM_STATUS;
    wire logic rdSec  = regReq.rdEn && regReq.addr == REG_SEC_STATUS;

    // Window comparison for the channel being converted.
    wire lsa_chan_t cur = chanIn[chan_r];
    wire logic outOfLimit = (cur.value > cur.highLimit) ||
                            (cur.value <= cur.lowLimit);
    wire logic storeNow = state_r == LSA_STORE;

    // Overtemperature hold latch on the selected remote channel.
    wire logic [7:0] otLimit = holdSelTwo ? REMOTE_TWO_OT_LIMIT
                                          : REMOTE_ONE_OT_LIMIT;
    wire logic [7:0] selTemp = holdSelTwo ? remoteTwoTemp : remoteOneTemp;
    wire logic aboveQuarter = (selTemp > otLimit) ||
                              (selTemp == otLimit && quarterAbove);
    wire logic belowLimit = selTemp < otLimit;

    // Live conditions for the secondary sources; bit 5 follows pin use.
    // The hold bit reports the latch only while the temperature has not
    // fallen back below the limit. Feeding the bare latch in would lock
    // up: the read could never clear the bit, so the latch never lets go.
    logic [7:0] secCond;
    always_comb begin
        secCond = ZERO_BYTE;
        secCond[7:6] = diodeFault;
        secCond[FAN_FOUR_BIT] = thermalEventSel ? thermalEventOver
                                                : fanFourSlow;
        secCond[4:2] = fanSlow;
        secCond[OVERTEMP_BIT] = overtempCond;
        secCond[HOLD_BIT] = holdSet && !belowLimit;
    end

    // Register write strobe decode, shared by every writable register.
    function automatic logic wrHit(input lsa_reg_req_t req,
                                   input logic [7:0]   addr);
        wrHit = req.wrEn && req.addr == addr;
    endfunction : wrHit

    // Configuration registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            configOne_r   <= CONFIG_ONE_RST;
            configTwo_r   <= ZERO_BYTE;
            configThree_r <= ZERO_BYTE;
            configFour_r  <= ZERO_BYTE;
        end else begin
            if (wrHit(regReq, REG_CONFIG_ONE)) begin
                configOne_r <= regReq.wrData;
            end
            if (wrHit(regReq, REG_CONFIG_TWO)) begin
                configTwo_r <= regReq.wrData;
            end
            if (wrHit(regReq, REG_CONFIG_THREE)) begin
                configThree_r <= regReq.wrData;
            end
            if (wrHit(regReq, REG_CONFIG_FOUR)) begin
                configFour_r <= regReq.wrData;
            end
        end
    end

    // Alert mask registers; the reserved secondary bit stays zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            primMask_r <= ZERO_BYTE;
            secMask_r  <= ZERO_BYTE;
        end else begin
            if (wrHit(regReq, REG_PRIM_MASK)) begin
                primMask_r <= regReq.wrData;
            end
            if (wrHit(regReq, REG_SEC_MASK)) begin
                secMask_r <= regReq.wrData & SEC_MASK_BITS;
            end
        end
    end

    // Round-robin sequencer; each channel owns one equal time slot.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r   <= LSA_IDLE;
            chan_r    <= 3'h0;
            slotCnt_r <= 32'h0;
            passDone  <= 1'b0;
        end else begin
            passDone <= 1'b0;
            case (state_r)
                LSA_IDLE: begin
                    chan_r    <= 3'h0;
                    slotCnt_r <= 32'h0;
                    if (monitorOn) begin
                        state_r <= LSA_CONVERT;
                    end
                end
                LSA_CONVERT: begin
                    slotCnt_r <= slotCnt_r + 32'h1;
                    // The slot timer paces the pass; convDone is only
                    // honoured once the slot has run its course.
                    if (slotCnt_r >= slotLen - 32'h1 && convDone) begin
                        state_r <= LSA_STORE;
                    end
                end
                LSA_STORE: begin
                    slotCnt_r <= 32'h0;
                    if (chan_r == 3'(NUM_CHANNELS - 1)) begin
                        chan_r   <= 3'h0;
                        passDone <= 1'b1;
                    end else begin
                        chan_r <= chan_r + 3'h1;
                    end
                    state_r <= monitorOn ? LSA_CONVERT : LSA_IDLE;
                end
                default: state_r <= LSA_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            convChannel <= 3'h0;
        end else begin
            convChannel <= chan_r;
        end
    end

    // Last comparison result per primary channel, kept between passes.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            primCond_r <= ZERO_BYTE;
        end else if (storeNow) begin
            primCond_r <= outOfLimit ? (primCond_r | chanBit(chan_r))
                                     : (primCond_r & ~chanBit(chan_r));
        end
    end

    // Primary status: set beats read-clear, and a read clears only bits
    // whose condition is already gone.
    logic [7:0] primKeep;
    logic [7:0] primEvent;
    logic [7:0] primStat_nxt;
    always_comb begin
        primKeep     = rdPrim ? (primStat_r & primCond_r) : primStat_r;
        primEvent    = (storeNow && outOfLimit) ? chanBit(chan_r)
                                                : ZERO_BYTE;
        primStat_nxt = (primKeep | primCond_r | primEvent)
                       & PRIM_SRC_BITS;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            primStat_r <= ZERO_BYTE;
        end else begin
            primStat_r <= primStat_nxt;
        end
    end

    // Secondary status: sticky except overtemperature, which tracks live.
    // Fan inputs arrive from their own free-running measurement logic.
    logic [7:0] secStat_nxt;
    always_comb begin
        secStat_nxt = (rdSec ? (secStat_r & secCond) : secStat_r)
                      | secCond;
        secStat_nxt[OVERTEMP_BIT] = secCond[OVERTEMP_BIT];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            secStat_r <= ZERO_BYTE;
        end else begin
            secStat_r <= secStat_nxt;
        end
    end

    // The latch lets go only once the temperature is back below the
    // limit and the host has cleared the hold status bit.
    wire logic holdRelease = belowLimit && !secStat_r[HOLD_BIT];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            holdSet <= 1'b0;
        end else if (aboveQuarter) begin
            holdSet <= 1'b1;
        end else if (holdRelease) begin
            holdSet <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overtempHold <= 1'b0;
            fansFull     <= 1'b0;
        end else begin
            overtempHold <= holdSet;
            fansFull <= holdSet && !configFour_r[NO_BOOST_BIT];
        end
    end

    // Alert combination.
    // A mask hides a source from the pin only; its status bit is untouched.
    logic [7:0] primHit;
    logic [7:0] secHit;
    for (genvar b = 0; b < 8; b++) begin : g_alert_src
        assign primHit[b] = primStat_r[b] && !primMask_r[b] &&
                            PRIM_SRC_BITS[b];
        assign secHit[b]  = secStat_r[b] && !secMask_r[b];
    end

    wire logic secPending = |secStat_r;
    wire logic secUnmasked = |secHit;
    wire logic summaryPath = secPending && (&secMask_r[7:1]) &&
                             !primMask_r[SUMMARY_BIT];
    wire logic alertAny = (|primHit) || secUnmasked || summaryPath;

    // Open drain: the data line is high in reset and low after it; the enable does the work.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            alertOut <= 1'b1;
        end else begin
            alertOut <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            alertOe <= 1'b0;
        end else begin
            alertOe <= alertAny && configThree_r[ALERT_EN_BIT];
        end
    end

    // Read data; the pre-clear value is returned.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData <= ZERO_BYTE;
        end else if (regReq.rdEn) begin
            case (regReq.addr)
                REG_CONFIG_ONE:   regRdData <= configOne_r;
                REG_PRIM_STATUS:  regRdData <= {secPending,
                                                primStat_r[6:0]};
                REG_SEC_STATUS:   regRdData <= secStat_r;
                REG_CONFIG_TWO:   regRdData <= configTwo_r;
                REG_PRIM_MASK:    regRdData <= primMask_r;
                REG_SEC_MASK:     regRdData <= secMask_r;
                REG_CONFIG_THREE: regRdData <= configThree_r;
                REG_CONFIG_FOUR:  regRdData <= configFour_r;
                default:          regRdData <= ZERO_BYTE;
            endcase
        end
    end

endmodule : lsa_limit_alert

/* File: hdl/lsa_pkg.sv */
package lsa_pkg;

    // Register offsets on the internal register port.
    localparam logic [7:0] REG_CONFIG_ONE   = 8'h40;
    localparam logic [7:0] REG_PRIM_STATUS  = 8'h41;
    localparam logic [7:0] REG_SEC_STATUS   = 8'h42;
    localparam logic [7:0] REG_CONFIG_TWO   = 8'h73;
    localparam logic [7:0] REG_PRIM_MASK    = 8'h74;
    localparam logic [7:0] REG_SEC_MASK     = 8'h75;
    localparam logic [7:0] REG_CONFIG_THREE = 8'h78;
    localparam logic [7:0] REG_CONFIG_FOUR  = 8'h7D;

    // Field positions.
    localparam int START_BIT      = 0;
    localparam int AVG_OFF_BIT    = 4;
    localparam int ALERT_EN_BIT   = 0;
    localparam int NO_BOOST_BIT   = 2;
    localparam int SUMMARY_BIT    = 7;
    localparam int OVERTEMP_BIT   = 1;
    localparam int HOLD_BIT       = 0;
    localparam int FAN_FOUR_BIT   = 5;

    // Status source bits of the primary register, writable bits of the secondary mask; primary bits 3 and 0 and secondary mask bit 0 are reserved.
    localparam logic [7:0] PRIM_SRC_BITS  = 8'h76;
    localparam logic [7:0] SEC_MASK_BITS  = 8'hFE;

    // Reset values.
    localparam logic [7:0] CONFIG_ONE_RST = 8'h01;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;

    // Pass times in microseconds.
    localparam int PASS_AVG_US    = 146000;
    localparam int PASS_FAST_US   = 19000;
    localparam int CLK_MHZ        = 100;
    localparam int NUM_CHANNELS   = 5;

    // One register access on the documented register port.
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } lsa_reg_req_t;

    // Per-channel conversion result with limits.
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] highLimit;
        logic [7:0] lowLimit;
    } lsa_chan_t;

    typedef enum logic [1:0] {
        LSA_IDLE    = 2'b00,
        LSA_CONVERT = 2'b01,
        LSA_STORE   = 2'b10
    } lsa_state_t;

endpackage : lsa_pkg

/* File: sim/lsa_conv_model.sv */
`timescale 1ns/1ps
module lsa_conv_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       slow,
    output logic            convDone
);
    logic [7:0] cntR;
    // A free-running result strobe; the slow setting stretches each wait.
    assign convDone = (cntR == (slow ? 8'h28 : 8'h02));
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cntR <= 8'h00;
        end else if (convDone) begin
            cntR <= 8'h00;
        end else begin
            cntR <= cntR + 8'h01;
        end
    end
endmodule : lsa_conv_model

/* File: sim/lsa_limit_alert_assertions.sv */
`timescale 1ns/1ps
module lsa_limit_alert_assertions
    import lsa_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         rst,
    input wire lsa_reg_req_t regReq,
    input wire logic [7:0]   regRdData,
    input wire logic [2:0]   fanSlow,
    input wire logic         alertOut,
    input wire logic         alertOe,
    input wire logic [2:0]   convChannel,
    input wire logic         passDone
);
    logic       enR;
    logic [7:0] secMaskR;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Only writes are visible here, so enable and mask are shadowed.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enR      <= 1'b0;
            secMaskR <= 8'h00;
        end else if (regReq.wrEn && regReq.addr == REG_CONFIG_THREE) begin
            enR <= regReq.wrData[ALERT_EN_BIT];
        end else if (regReq.wrEn && regReq.addr == REG_SEC_MASK) begin
            secMaskR <= regReq.wrData;
        end
    end
    sequence s_fan_rise;
        $rose(fanSlow[0]) && enR && !secMaskR[2];
    endsequence
    a_fan_alert_on: assert property (s_fan_rise |-> ##[1:3] alertOe)
        else $error("alert not raised for slow fan");
    a_alert_off_dis: assert property (!enR && !$past(enR) |-> !alertOe)
        else $error("alert driven while disabled");
    a_line_low: assert property (!$past(rst) |-> alertOut == 1'b0)
        else $error("alert line data not low");
    a_pass_single: assert property (passDone |=> !passDone)
        else $error("pass pulse longer than one cycle");
    a_pass_after_last: assert property ($rose(passDone) |-> $past(convChannel) == 3'h4)
        else $error("pass end not after last channel");
    a_chan_bound: assert property (convChannel <= 3'h4)
        else $error("channel index out of range");
    a_read_hold: assert property (!$past(regReq.rdEn) && !$past(rst) |-> $stable(regRdData))
        else $error("read data changed without a read");
    a_mask_readback: assert property (regReq.rdEn && regReq.addr == REG_SEC_MASK |=> regRdData == (secMaskR & SEC_MASK_BITS))
        else $error("secondary mask read back wrong");
endmodule : lsa_limit_alert_assertions

bind lsa_limit_alert lsa_limit_alert_assertions lsa_limit_alert_assertions_inst (
    .ref_clk(ref_clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
    .fanSlow(fanSlow), .alertOut(alertOut), .alertOe(alertOe),
    .convChannel(convChannel), .passDone(passDone));

/* File: sim/lsa_limit_alert_tb_top.sv */
`timescale 1ns/1ps
module lsa_limit_alert_tb_top
    import lsa_pkg::*;
;
    logic                         ref_clk = 1'b0;
    logic                         rst = 1'b1;
    lsa_reg_req_t                 regReq = '0;
    lsa_chan_t [NUM_CHANNELS-1:0] chanIn;
    logic [2:0]                   fanSlow = 3'h0;
    logic [1:0]                   diodeFault = 2'h0;
    logic                         fanFourSlow = 1'b0;
    logic                         evOver = 1'b0;
    logic                         evSel = 1'b0;
    logic                         overtempCond = 1'b0;
    logic                         slow = 1'b0;
    logic                         holdSelTwo = 1'b0;
    logic                         quarterAbove = 1'b0;
    logic [7:0]                   remoteOneTemp = 8'h00;
    logic [7:0]                   remoteTwoTemp = 8'h00;
    logic                         fansFull, overtempHold;
    logic                         convDone, alertOut, alertOe, passDone;
    logic [2:0]                   convChannel;
    logic [7:0]                   regRdData;
    int                           n_errors = 0;
    int                           checked = 0;
    int                           cycles = 0;
    logic [7:0]                   bitOf [5] = '{8'h02, 8'h04, 8'h20, 8'h10, 8'h40};

    always #5 ref_clk = ~ref_clk;

    lsa_limit_alert #(.PASS_AVG_CYCLES(50), .PASS_FAST_CYCLES(25))
        lsa_limit_alert_inst (
        .ref_clk(ref_clk), .rst(rst), .regReq(regReq),
        .regRdData(regRdData), .chanIn(chanIn), .convDone(convDone),
        .fanSlow(fanSlow), .fanFourSlow(fanFourSlow),
        .thermalEventOver(evOver), .thermalEventSel(evSel),
        .diodeFault(diodeFault), .overtempCond(overtempCond),
        .holdSelTwo(holdSelTwo), .remoteOneTemp(remoteOneTemp),
        .remoteTwoTemp(remoteTwoTemp), .quarterAbove(quarterAbove),
        .alertOut(alertOut), .alertOe(alertOe), .fansFull(fansFull),
        .overtempHold(overtempHold), .convChannel(convChannel),
        .passDone(passDone));

    lsa_conv_model lsa_conv_model_inst (.ref_clk(ref_clk), .rst(rst),
        .slow(slow), .convDone(convDone));

    task automatic complete_run();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // A hang in any wait below ends the run here.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regReq <= '{1'b1, 1'b0, a, d};
        @(negedge ref_clk);
        regReq <= '0;
    endtask : wr

    task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk);
        regReq <= '0;
        check(regRdData, exp);
    endtask : rdck

    task automatic oeck(input logic exp);
        check({7'h00, alertOe}, {7'h00, exp});
    endtask : oeck

    task automatic wait_pass(input int n);
        repeat (n) @(posedge passDone);
        @(negedge ref_clk);
    endtask : wait_pass

    task automatic t_reset();
        rdck(REG_CONFIG_ONE, CONFIG_ONE_RST);
        rdck(REG_PRIM_MASK, ZERO_BYTE);
        rdck(8'h10, ZERO_BYTE);
        oeck(1'b0);
        wr(REG_SEC_MASK, 8'hFF);
        rdck(REG_SEC_MASK, SEC_MASK_BITS);
        wr(REG_SEC_MASK, ZERO_BYTE);
    endtask : t_reset

    task automatic t_secondary();
        logic [5:0] src;
        wr(REG_CONFIG_THREE, 8'h01);
        for (int i = 0; i < 6; i++) begin
            src = 6'h01 << i;
            {diodeFault, fanFourSlow, fanSlow} <= src;
            cyc(3);
            oeck(1'b1);
            rdck(REG_PRIM_STATUS, 8'h80);
            {diodeFault, fanFourSlow, fanSlow} <= 6'h00;
            cyc(3);
            oeck(1'b1);
            rdck(REG_SEC_STATUS, {src, 2'b00});
            rdck(REG_SEC_STATUS, ZERO_BYTE);
            cyc(2);
            oeck(1'b0);
        end
        evSel <= 1'b1;
        evOver <= 1'b1;
        cyc(3);
        evOver <= 1'b0;
        cyc(2);
        rdck(REG_SEC_STATUS, 8'h20);
        evSel <= 1'b0;
    endtask : t_secondary

    task automatic t_mask();
        wr(REG_SEC_MASK, SEC_MASK_BITS);
        wr(REG_PRIM_MASK, 8'h80);
        fanSlow <= 3'h1;
        cyc(4);
        oeck(1'b0);
        wr(REG_PRIM_MASK, ZERO_BYTE);
        cyc(3);
        oeck(1'b1);
        fanSlow <= 3'h0;
        cyc(2);
        rdck(REG_SEC_STATUS, 8'h04);
        wr(REG_SEC_MASK, ZERO_BYTE);
    endtask : t_mask

    task automatic t_overtemp();
        overtempCond <= 1'b1;
        cyc(3);
        rdck(REG_SEC_STATUS, 8'h02);
        overtempCond <= 1'b0;
        cyc(3);
        oeck(1'b0);
        rdck(REG_SEC_STATUS, ZERO_BYTE);
    endtask : t_overtemp

    task automatic t_hold();
        remoteOneTemp <= 8'h64;
        cyc(3);
        check({6'h00, fansFull, overtempHold}, 8'h00);
        quarterAbove <= 1'b1;
        cyc(3);
        check({6'h00, fansFull, overtempHold}, 8'h03);
        remoteOneTemp <= 8'h00;
        quarterAbove <= 1'b0;
        cyc(3);
        check({7'h00, overtempHold}, 8'h01);
        rdck(REG_SEC_STATUS, 8'h01);
        cyc(3);
        check({7'h00, overtempHold}, 8'h00);
        wr(REG_CONFIG_FOUR, 8'h04);
        holdSelTwo <= 1'b1;
        remoteTwoTemp <= 8'h89;
        cyc(3);
        check({6'h00, fansFull, overtempHold}, 8'h01);
        remoteTwoTemp <= 8'h00;
        cyc(2);
        rdck(REG_SEC_STATUS, 8'h01);
        cyc(3);
        check({7'h00, overtempHold}, 8'h00);
        wr(REG_CONFIG_FOUR, ZERO_BYTE);
        holdSelTwo <= 1'b0;
    endtask : t_hold

    task automatic t_primary();
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            slow <= i[0];
            chanIn[i].value <= 8'h81;
            wait_pass(2);
            chanIn[i].value <= 8'h80;
            wait_pass(2);
            rdck(REG_PRIM_STATUS, bitOf[i]);
            rdck(REG_PRIM_STATUS, ZERO_BYTE);
        end
        chanIn[1].value <= 8'h10;
        wait_pass(2);
        rdck(REG_PRIM_STATUS, 8'h04);
        chanIn[1].value <= 8'h11;
        wait_pass(2);
        rdck(REG_PRIM_STATUS, 8'h04);
        rdck(REG_PRIM_STATUS, ZERO_BYTE);
    endtask : t_primary

    task automatic t_stop();
        int seen;
        seen = 0;
        wr(REG_CONFIG_TWO, 8'h10);
        wr(REG_CONFIG_ONE, ZERO_BYTE);
        cyc(30);
        repeat (200) begin
            @(negedge ref_clk);
            seen += passDone;
        end
        check(seen[7:0], 8'h00);
        wr(REG_CONFIG_ONE, 8'h01);
        wait_pass(1);
        check({7'h00, passDone}, 8'h01);
    endtask : t_stop

    initial begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            chanIn[i] = '{8'h40, 8'h80, 8'h10};
        end
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_secondary();
        t_mask();
        t_overtemp();
        t_hold();
        t_primary();
        t_stop();
        complete_run();
    end
endmodule : lsa_limit_alert_tb_top
